// ### common/pkp_pkg.sv
/*
  shared constants, types and register layout of the panel key/level controller.
  assumes a 50 MHz clock; key inputs already debounced and synchronous.
*/
// Contract
// - escape at live reading shows maximum and lights the max lamp.
// - escape at maximum shows minimum and lights the min lamp.
// - escape at minimum returns to live reading, both peak lamps off.
// - escape held one second loads both peaks with the live value.
// - temperature model adds correction, clamped to -1999..9999, to each reading.
// - ten idle seconds in adjustment level return to live operation display.
// - operate_adjust_lock 1 blocks adjustment, 2 also blocks setpoint display.
// - setup_level_lock 1 blocks advanced level, 2 blocks initial level too.
// - edit_change_lock blocks change state except protect level and password.
// - zero_key_lock makes the process meter ignore zero set and clear keys.
// - level plus mode held for protect time, default 5 s, enters protect.
// - level plus mode held one second leaves protect level.
// - level key held three seconds enters initial level at input type.
// - process input type codes 0..5, temperature codes 0..18.
// - process type change restores scaling defaults and cancels forced zero.
// - temperature type change leaves all other settings untouched.
// - second value key press enters change state; advancing commits value.
package pkp_pkg;
  localparam int VW = 20;
  localparam int TW = 32;
  localparam int AW = 4;
  typedef logic signed [VW-1:0] pkp_val_t;
  typedef struct packed {
    logic esc;
    logic lvl;
    logic mode;
    logic shift;
    logic up;
    logic down;
  } pkp_keys_t;
  typedef struct packed {
    pkp_val_t inp1;
    pkp_val_t dsp1;
    pkp_val_t inp2;
    pkp_val_t dsp2;
    logic [2:0] dp;
  } pkp_scale_t;
  typedef enum logic [2:0] {
    LV_OPER = 3'b000, LV_ADJ = 3'b001, LV_INIT = 3'b010, LV_ADV = 3'b011, LV_PROT = 3'b100
  } pkp_level_t;
  typedef enum logic [1:0] {DM_LIVE = 2'b00, DM_MAX = 2'b01, DM_MIN = 2'b10, DM_SP = 2'b11}
    pkp_disp_t;
  typedef enum logic [1:0] {ES_PARAM = 2'b00, ES_MON = 2'b01, ES_CHG = 2'b10} pkp_edit_t;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned NS_PER_SEC = 1000000000;
  localparam int unsigned CYC_PER_SEC = NS_PER_SEC / CLK_PERIOD_NS;
  localparam int unsigned ESC_HOLD_S = 1;
  localparam int unsigned INIT_HOLD_S = 3;
  localparam int unsigned LEAVE_HOLD_S = 1;
  localparam int unsigned ZERO_HOLD_S = 1;
  localparam int unsigned IDLE_S = 10;
  localparam logic [7:0] PROT_DEF_S = 8'h05;
  localparam logic [7:0] PROT_MIN_S = 8'h01;
  localparam int T_ESC = 0;
  localparam int T_LVL = 1;
  localparam int T_COMBO = 2;
  localparam int T_SHIFT = 3;
  localparam int T_IDLE = 4;
  localparam int NUM_TMR = 5;

  ////////////////////////////////////////////////////////////////////////////////
  localparam pkp_val_t CORR_MIN = -20'sh007cf;
  localparam pkp_val_t CORR_MAX = 20'sh0270f;
  localparam pkp_val_t ADV_PASSWORD = -20'sh000a9;
  localparam pkp_val_t VAL_MIN = 20'sh80000;
  localparam pkp_val_t VAL_MAX = 20'sh7ffff;
  localparam logic [4:0] PROC_TYPE_MAX = 5'h05;
  localparam logic [4:0] TEMP_TYPE_MAX = 5'h12;
  localparam logic [4:0] TYPE_DEF = 5'h00;
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_ALL = 2'h2;
  localparam logic [1:0] PIDX_PASS = 2'h1;
  localparam pkp_scale_t SCALE_DEF = '{inp1: 20'sh00000, dsp1: 20'sh00000,
    inp2: 20'sh003e8, dsp2: 20'sh003e8, dp: 3'h0};

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [AW-1:0] RA_CTRL = 4'h0;
  localparam logic [AW-1:0] RA_CORR = 4'h1;
  localparam logic [AW-1:0] RA_TYPE = 4'h2;
  localparam logic [AW-1:0] RA_SP = 4'h3;
  localparam logic [AW-1:0] RA_STAT = 4'h4;
  localparam logic [AW-1:0] RA_LIVE = 4'h5;
  localparam logic [AW-1:0] RA_MAX = 4'h6;
  localparam logic [AW-1:0] RA_MIN = 4'h7;
  localparam logic [AW-1:0] RA_INP1 = 4'h8;
  localparam logic [AW-1:0] RA_DSP1 = 4'h9;
  localparam logic [AW-1:0] RA_INP2 = 4'ha;
  localparam logic [AW-1:0] RA_DSP2 = 4'hb;
  localparam logic [AW-1:0] RA_DP = 4'hc;
  localparam int CF_TEMP = 0;
  localparam int CF_OAL = 1;
  localparam int CF_SLL = 3;
  localparam int CF_EDL = 5;
  localparam int CF_ZRL = 6;
  localparam int CF_PROT = 8;

  function automatic pkp_val_t clampCorr(input pkp_val_t v);
    clampCorr = (v < CORR_MIN) ? CORR_MIN : ((v > CORR_MAX) ? CORR_MAX : v);
  endfunction : clampCorr

  function automatic logic [4:0] clampType(input pkp_val_t v, input logic temp);
    logic [4:0] top;
    top = temp ? TEMP_TYPE_MAX : PROC_TYPE_MAX;
    clampType = (v < 0) ? TYPE_DEF : ((v > pkp_val_t'(top)) ? top : v[4:0]);
  endfunction : clampType

  function automatic logic [1:0] lock2(input logic [1:0] v);
    lock2 = (v > LOCK_ALL) ? LOCK_ALL : v;
  endfunction : lock2
endpackage : pkp_pkg

// ### hw/pkp_hold_timer.sv
/*
  key hold timer: counts clock cycles while its input stays active.
  assumes a synchronous active input; count restarts from zero on release.
*/
`timescale 1ns/100ps
module pkp_hold_timer #(
  parameter int CW = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic active,
  output logic [CW-1:0] count
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // saturates so a long hold never wraps into a false short press
  always_comb begin
    cnt_d = '0;
    if (active) begin
      cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;
endmodule : pkp_hold_timer

// ### hw/pkp_panel_ctrl.sv
/*
  panel key and level controller: peak display, correction, key protect, levels.
  assumes debounced synchronous keys and one measurement strobe per reading.
*/
`timescale 1ns/100ps
module pkp_panel_ctrl #(
  parameter int unsigned SEC_CYCLES = pkp_pkg::CYC_PER_SEC
) (
  input wire logic clk,
  input wire logic srst,
  input wire pkp_pkg::pkp_keys_t keys,
  input wire logic measValid,
  input wire logic measOk,
  input wire pkp_pkg::pkp_val_t measRaw,
  input wire logic [pkp_pkg::AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output pkp_pkg::pkp_val_t dispValue,
  output logic annMax,
  output logic annMin,
  output logic svLamp,
  output logic blink,
  output logic zeroLamp,
  output pkp_pkg::pkp_level_t levelInd
);
  import pkp_pkg::*;

  logic [TW-1:0] tCnt [NUM_TMR];
  logic [NUM_TMR-1:0] tAct;
  logic [TW-1:0] limEsc, limLeave, limInit, limZero, limIdle, limProt;
  pkp_keys_t kPrev_q, prs, rls;
  pkp_level_t level_q, level_d;
  pkp_disp_t dm_q, dm_d;
  pkp_edit_t es_q, es_d;
  logic [1:0] pIdx_q, pIdx_d, oal_q, oal_d, sll_q, sll_d;
  pkp_val_t editV_q, editV_d, live_q, live_d, max_q, max_d, min_q, min_d;
  pkp_val_t zOff_q, zOff_d, corr_q, corr_d, sp_q, sp_d, disp_q, disp_d;
  pkp_val_t curVal, liveCalc;
  logic zeroOn_q, zeroOn_d, edl_q, edl_d, zrl_q, zrl_d, temp_q, temp_d;
  logic seen_q, seen_d;
  logic [4:0] inType_q, inType_d, typeNew;
  logic [7:0] prot_q, prot_d;
  pkp_scale_t scale_q, scale_d;
  logic [31:0] rdata_q, rdata_d;
  logic annMax_q, annMax_d, annMin_q, annMin_d, sv_q, sv_d, blink_q, blink_d;
  logic typeReq, typeChg, chgBlock, viewOk, zeroOk, advKey;
  logic escTap, escLong, lvlTap, lvlInit, lvlLeave, comboIn, comboOut, idleHit;
  logic zeroSet, zeroClr;

  ////////////////////////////////////////////////////////////////////////////////
  assign limEsc = TW'(ESC_HOLD_S * SEC_CYCLES);
  assign limLeave = TW'(LEAVE_HOLD_S * SEC_CYCLES);
  assign limInit = TW'(INIT_HOLD_S * SEC_CYCLES);
  assign limZero = TW'(ZERO_HOLD_S * SEC_CYCLES);
  assign limIdle = TW'(IDLE_S * SEC_CYCLES);
  assign limProt = TW'(TW'(prot_q) * TW'(SEC_CYCLES));

  assign tAct[T_ESC] = keys.esc;
  assign tAct[T_LVL] = keys.lvl & ~keys.mode;
  assign tAct[T_COMBO] = keys.lvl & keys.mode;
  assign tAct[T_SHIFT] = keys.shift;
  assign tAct[T_IDLE] = (level_q == LV_ADJ) && (keys == '0);

  for (genvar g = 0; g < NUM_TMR; g++) begin : gTmr
    pkp_hold_timer #(.CW(TW)) uTmr (
      .clk(clk),
      .srst(srst),
      .active(tAct[g]),
      .count(tCnt[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign prs = keys & ~kPrev_q;
  assign rls = ~keys & kPrev_q;
  assign viewOk = (level_q == LV_OPER) && (es_q == ES_PARAM) && (dm_q != DM_SP);
  assign escTap = viewOk && rls.esc && (tCnt[T_ESC] < limEsc);
  assign escLong = viewOk && tAct[T_ESC] && (tCnt[T_ESC] == limEsc);
  assign lvlTap = rls.lvl && !keys.mode && !seen_q && (tCnt[T_LVL] < limLeave);
  assign lvlInit = tAct[T_LVL] && (tCnt[T_LVL] == limInit);
  assign lvlLeave = tAct[T_LVL] && (tCnt[T_LVL] == limLeave);
  assign comboIn = tAct[T_COMBO] && (tCnt[T_COMBO] == limProt);
  assign comboOut = tAct[T_COMBO] && (tCnt[T_COMBO] == limLeave);
  assign idleHit = tAct[T_IDLE] && (tCnt[T_IDLE] == limIdle);
  assign zeroOk = viewOk && (dm_q == DM_LIVE) && !temp_q && measOk;
  assign zeroSet = zeroOk && !zrl_q && rls.shift && (tCnt[T_SHIFT] < limZero);
  assign zeroClr = zeroOk && !zrl_q && tAct[T_SHIFT] && (tCnt[T_SHIFT] == limZero);
  assign chgBlock = edl_q && (level_q != LV_PROT) &&
                    !((level_q == LV_INIT) && (pIdx_q == PIDX_PASS));
  assign advKey = prs.mode && !keys.lvl;
  assign liveCalc = temp_q ? measRaw + corr_q : (zeroOn_q ? measRaw - zOff_q : measRaw);

  always_comb begin
    curVal = '0;
    unique case (level_q)
      LV_OPER: curVal = sp_q;
      LV_ADJ: curVal = corr_q;
      LV_INIT: curVal = (pIdx_q == 2'h0) ? pkp_val_t'(inType_q) : '0;
      LV_ADV: curVal = pkp_val_t'(prot_q);
      LV_PROT: begin
        unique case (pIdx_q)
          2'h0: curVal = pkp_val_t'(oal_q);
          2'h1: curVal = pkp_val_t'(sll_q);
          2'h2: curVal = pkp_val_t'(edl_q);
          2'h3: curVal = pkp_val_t'(zrl_q);
        endcase
      end
      default: curVal = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    level_d = level_q;
    dm_d = dm_q;
    es_d = es_q;
    pIdx_d = pIdx_q;
    editV_d = editV_q;
    live_d = live_q;
    max_d = max_q;
    min_d = min_q;
    zOff_d = zOff_q;
    zeroOn_d = zeroOn_q;
    corr_d = corr_q;
    sp_d = sp_q;
    oal_d = oal_q;
    sll_d = sll_q;
    edl_d = edl_q;
    zrl_d = zrl_q;
    temp_d = temp_q;
    prot_d = prot_q;
    inType_d = inType_q;
    scale_d = scale_q;
    typeReq = 1'b0;
    typeNew = inType_q;
    seen_d = (seen_q | tAct[T_COMBO] | (keys.lvl && (level_q != LV_OPER))) & (keys != '0);
    if (measValid) begin
      live_d = liveCalc;
      if (liveCalc > max_q) max_d = liveCalc;
      if (liveCalc < min_q) min_d = liveCalc;
    end
    if (escLong) begin
      max_d = live_q;
      min_d = live_q;
    end
    if (escTap) begin
      unique case (dm_q)
        DM_LIVE: dm_d = DM_MAX;
        DM_MAX: dm_d = DM_MIN;
        DM_MIN: dm_d = DM_LIVE;
        DM_SP: dm_d = DM_SP;
      endcase
    end
    if (zeroSet) begin
      zeroOn_d = 1'b1;
      zOff_d = zOff_q + live_q;
    end
    if (zeroClr) begin
      zeroOn_d = 1'b0;
      zOff_d = '0;
    end
    unique case (level_q)
      LV_OPER: begin
        if (comboIn) level_d = LV_PROT;
        else if (lvlInit && (sll_q != LOCK_ALL)) level_d = LV_INIT;
        else if (lvlTap && (oal_q == LOCK_NONE)) level_d = LV_ADJ;
      end
      LV_ADJ: if (prs.lvl || idleHit) level_d = LV_OPER;
      LV_INIT, LV_ADV: if (lvlLeave) level_d = LV_OPER;
      LV_PROT: if (comboOut) level_d = LV_OPER;
      default: level_d = LV_OPER;
    endcase
    if (advKey) begin
      if (es_q == ES_CHG) begin
        unique case (level_q)
          LV_OPER: sp_d = editV_q;
          LV_ADJ: corr_d = clampCorr(editV_q);
          LV_INIT: begin
            if (pIdx_q == 2'h0) begin
              typeReq = 1'b1;
              typeNew = clampType(editV_q, temp_q);
            end else if ((editV_q == ADV_PASSWORD) && (sll_q == LOCK_NONE)) begin
              level_d = LV_ADV;
            end
          end
          LV_ADV: prot_d = (editV_q[7:0] == 8'h00) ? PROT_MIN_S : editV_q[7:0];
          LV_PROT: begin
            unique case (pIdx_q)
              2'h0: oal_d = lock2(editV_q[1:0]);
              2'h1: sll_d = lock2(editV_q[1:0]);
              2'h2: edl_d = editV_q[0];
              2'h3: zrl_d = editV_q[0];
            endcase
          end
          default: ;
        endcase
      end
      es_d = ES_PARAM;
      if (level_q == LV_OPER) begin
        dm_d = ((dm_q != DM_SP) && (oal_q != LOCK_ALL)) ? DM_SP : DM_LIVE;
      end else begin
        pIdx_d = (pIdx_q == ((level_q == LV_PROT) ? 2'h3 : ((level_q == LV_INIT) ?
                  PIDX_PASS : 2'h0))) ? 2'h0 : pIdx_q + 2'h1;
      end
    end
    if (prs.shift && !((level_q == LV_OPER) && (dm_q != DM_SP))) begin
      unique case (es_q)
        ES_PARAM: es_d = ES_MON;
        ES_MON: begin
          if (!chgBlock) begin
            es_d = ES_CHG;
            editV_d = curVal;
          end
        end
        ES_CHG: es_d = ES_CHG;
        default: es_d = ES_PARAM;
      endcase
    end
    if (es_q == ES_CHG) begin
      if (prs.up) editV_d = editV_q + 20'sh00001;
      else if (prs.down) editV_d = editV_q - 20'sh00001;
    end
    if (wr) begin
      unique case (addr)
        RA_CTRL: begin
          temp_d = wdata[CF_TEMP];
          oal_d = lock2(wdata[CF_OAL+:2]);
          sll_d = lock2(wdata[CF_SLL+:2]);
          edl_d = wdata[CF_EDL];
          zrl_d = wdata[CF_ZRL];
          prot_d = (wdata[CF_PROT+:8] == 8'h00) ? PROT_MIN_S : wdata[CF_PROT+:8];
        end
        RA_CORR: corr_d = clampCorr(wdata[VW-1:0]);
        RA_TYPE: begin
          typeReq = 1'b1;
          typeNew = clampType(wdata[VW-1:0], temp_q);
        end
        RA_SP: sp_d = wdata[VW-1:0];
        default: ;
      endcase
    end
    typeChg = typeReq && (typeNew != inType_q);
    if (typeChg) begin
      inType_d = typeNew;
      if (!temp_q) begin
        scale_d = SCALE_DEF;
        zeroOn_d = 1'b0;
        zOff_d = '0;
      end
    end
    if (level_d != level_q) begin
      es_d = ES_PARAM;
      pIdx_d = 2'h0;
      dm_d = DM_LIVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_d = '0;
    if (rd) begin
      unique case (addr)
        RA_CTRL: rdata_d = {16'h0000, prot_q, 1'b0, zrl_q, edl_q, sll_q, oal_q, temp_q};
        RA_CORR: rdata_d = 32'(corr_q);
        RA_TYPE: rdata_d = 32'(inType_q);
        RA_SP: rdata_d = 32'(sp_q);
        RA_STAT: rdata_d = {24'h000000, zeroOn_q, es_q, dm_q, level_q};
        RA_LIVE: rdata_d = 32'(live_q);
        RA_MAX: rdata_d = 32'(max_q);
        RA_MIN: rdata_d = 32'(min_q);
        RA_INP1: rdata_d = 32'(scale_q.inp1);
        RA_DSP1: rdata_d = 32'(scale_q.dsp1);
        RA_INP2: rdata_d = 32'(scale_q.inp2);
        RA_DSP2: rdata_d = 32'(scale_q.dsp2);
        RA_DP: rdata_d = 32'(scale_q.dp);
        default: rdata_d = '0;
      endcase
    end
    disp_d = '0;
    if (es_d == ES_CHG) disp_d = editV_d;
    else if (es_d == ES_MON) disp_d = curVal;
    else if (level_d == LV_OPER) begin
      unique case (dm_d)
        DM_LIVE: disp_d = live_d;
        DM_MAX: disp_d = max_d;
        DM_MIN: disp_d = min_d;
        DM_SP: disp_d = sp_d;
      endcase
    end
    annMax_d = (level_d == LV_OPER) && (dm_d == DM_MAX);
    annMin_d = (level_d == LV_OPER) && (dm_d == DM_MIN);
    sv_d = es_d != ES_PARAM;
    blink_d = es_d == ES_CHG;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      kPrev_q <= '0;
      level_q <= LV_OPER;
      dm_q <= DM_LIVE;
      es_q <= ES_PARAM;
      pIdx_q <= 2'h0;
      editV_q <= '0;
      live_q <= '0;
      max_q <= VAL_MIN;
      min_q <= VAL_MAX;
      zOff_q <= '0;
      zeroOn_q <= 1'b0;
      corr_q <= '0;
      sp_q <= '0;
      oal_q <= LOCK_NONE;
      sll_q <= LOCK_NONE;
      edl_q <= 1'b0;
      zrl_q <= 1'b0;
      temp_q <= 1'b0;
      seen_q <= 1'b0;
      prot_q <= PROT_DEF_S;
      inType_q <= TYPE_DEF;
      scale_q <= SCALE_DEF;
      rdata_q <= '0;
      disp_q <= '0;
      annMax_q <= 1'b0;
      annMin_q <= 1'b0;
      sv_q <= 1'b0;
      blink_q <= 1'b0;
    end else begin
      kPrev_q <= keys;
      level_q <= level_d;
      dm_q <= dm_d;
      es_q <= es_d;
      pIdx_q <= pIdx_d;
      editV_q <= editV_d;
      live_q <= live_d;
      max_q <= max_d;
      min_q <= min_d;
      zOff_q <= zOff_d;
      zeroOn_q <= zeroOn_d;
      corr_q <= corr_d;
      sp_q <= sp_d;
      oal_q <= oal_d;
      sll_q <= sll_d;
      edl_q <= edl_d;
      zrl_q <= zrl_d;
      temp_q <= temp_d;
      seen_q <= seen_d;
      prot_q <= prot_d;
      inType_q <= inType_d;
      scale_q <= scale_d;
      rdata_q <= rdata_d;
      disp_q <= disp_d;
      annMax_q <= annMax_d;
      annMin_q <= annMin_d;
      sv_q <= sv_d;
      blink_q <= blink_d;
    end
  end

  assign rdata = rdata_q;
  assign dispValue = disp_q;
  assign annMax = annMax_q;
  assign annMin = annMin_q;
  assign svLamp = sv_q;
  assign blink = blink_q;
  assign zeroLamp = zeroOn_q;
  assign levelInd = level_q;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_tap(pkp_disp_t from);
    escTap && (dm_q == from);
  endsequence
  property p_view_max;
    @(posedge clk) disable iff (srst) s_tap(DM_LIVE) |=> (dm_q == DM_MAX) && annMax && !annMin;
  endproperty
  a_view_max: assert property (p_view_max) else $error("max view missing");
  property p_view_min;
    @(posedge clk) disable iff (srst) s_tap(DM_MAX) |=> (dm_q == DM_MIN) && annMin && !annMax;
  endproperty
  a_view_min: assert property (p_view_min) else $error("min view missing");
  property p_view_live;
    @(posedge clk) disable iff (srst) s_tap(DM_MIN) |=> (dm_q == DM_LIVE) && !annMin && !annMax;
  endproperty
  a_view_live: assert property (p_view_live) else $error("live view missing");
  property p_peak_reset;
    @(posedge clk) disable iff (srst)
      escLong |=> (max_q == $past(live_q)) && (min_q == $past(live_q));
  endproperty
  a_peak_reset: assert property (p_peak_reset) else $error("peak reset wrong");
  property p_corr;
    @(posedge clk) disable iff (srst)
      (measValid && temp_q) |=> live_q == pkp_val_t'($past(measRaw) + $past(corr_q));
  endproperty
  a_corr: assert property (p_corr) else $error("correction not applied");
  property p_idle;
    @(posedge clk) disable iff (srst) idleHit |=> (level_q == LV_OPER) && (dm_q == DM_LIVE);
  endproperty
  a_idle: assert property (p_idle) else $error("idle return missing");
  property p_adj_lock;
    @(posedge clk) disable iff (srst)
      (level_q == LV_OPER && oal_q != LOCK_NONE) |=> level_q != LV_ADJ;
  endproperty
  a_adj_lock: assert property (p_adj_lock) else $error("adjust entry not locked");
  property p_edit_lock;
    @(posedge clk) disable iff (srst) (chgBlock && es_q != ES_CHG) |=> es_q != ES_CHG;
  endproperty
  a_edit_lock: assert property (p_edit_lock) else $error("change lock bypassed");
  property p_zero_lock;
    @(posedge clk) disable iff (srst) (zrl_q && !zeroOn_q) |=> !zeroOn_q;
  endproperty
  a_zero_lock: assert property (p_zero_lock) else $error("zero lock bypassed");
  property p_prot_in;
    @(posedge clk) disable iff (srst)
      (level_q == LV_OPER && comboIn) |=> levelInd == LV_PROT ##1 level_q == LV_PROT;
  endproperty
  a_prot_in: assert property (p_prot_in) else $error("protect entry missing");
  property p_type_proc;
    @(posedge clk) disable iff (srst)
      (typeChg && !temp_q) |=> !zeroOn_q && (scale_q == SCALE_DEF);
  endproperty
  a_type_proc: assert property (p_type_proc) else $error("type side effects missing");
  property p_peak_track;
    @(posedge clk) disable iff (srst)
      (measValid && !escLong && liveCalc > max_q) |=> max_q == $past(liveCalc);
  endproperty
  a_peak_track: assert property (p_peak_track) else $error("max not tracked");
endmodule : pkp_panel_ctrl

// ### bench/pkp_operator.sv
/*
  operator model: presses and releases the front-panel keys.
  assumes the controller samples the key levels on the rising clock edge.
*/
`timescale 1ns/100ps
module pkp_operator (
  input wire logic clk,
  output pkp_pkg::pkp_keys_t keys
);
  import pkp_pkg::*;
  initial keys = '0;
  // call right after an edge: hold the keys for n edges, then let go of all
  task automatic act(input pkp_keys_t k, input int n);
    keys <= k;
    repeat (n) @(posedge clk);
    keys <= '0;
  endtask : act
endmodule : pkp_operator

// ### bench/pkp_panel_ctrl_tb.sv
/*
  self-checking bench for the panel key and level controller.
  assumes the operator model drives the keys; one second is S clock cycles.
*/
`timescale 1ns/100ps
module pkp_panel_ctrl_tb;
  import pkp_pkg::*;
  localparam int S = 20;
  localparam pkp_keys_t ESC = 6'h20;
  localparam pkp_keys_t LVL = 6'h10;
  localparam pkp_keys_t COMBO = 6'h18;
  localparam pkp_keys_t MODE = 6'h08;
  localparam pkp_keys_t SHIFT = 6'h04;
  localparam pkp_keys_t UP = 6'h02;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic measValid = 1'b0;
  logic measOk = 1'b1;
  pkp_val_t measRaw = '0;
  logic [AW-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  pkp_val_t dispValue;
  logic annMax;
  logic annMin;
  logic svLamp;
  logic blink;
  logic zeroLamp;
  pkp_level_t levelInd;
  pkp_keys_t keys;
  int failCount = 0;
  int samplesChecked = 0;

  always #10 clk = ~clk;

  pkp_operator op (.clk(clk), .keys(keys));
  pkp_panel_ctrl #(.SEC_CYCLES(S)) dut (.clk(clk), .srst(srst), .keys(keys),
    .measValid(measValid), .measOk(measOk), .measRaw(measRaw), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .dispValue(dispValue), .annMax(annMax), .annMin(annMin),
    .svLamp(svLamp), .blink(blink), .zeroLamp(zeroLamp), .levelInd(levelInd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wrReg(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrReg

  // read data stand only in the cycle after the strobe
  task automatic rdReg(input logic [AW-1:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(what, exp, rdata);
  endtask : rdReg

  task automatic meas(input pkp_val_t v);
    @(posedge clk);
    measValid <= 1'b1;
    measRaw <= v;
    @(posedge clk);
    measValid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : meas

  task automatic press(input pkp_keys_t k, input int n, input int w);
    @(posedge clk);
    op.act(k, n);
    repeat (w) @(posedge clk);
    #1;
  endtask : press

  task automatic lvlIs(input pkp_level_t e);
    check("levelInd", {29'h0, e}, {29'h0, levelInd});
  endtask : lvlIs

  ////////////////////////////////////////////////////////////////////////////////
  task automatic peaks;
    wrReg(RA_CTRL, 32'h501);
    meas(5);
    meas(9);
    meas(3);
    rdReg(RA_MAX, 32'h9, "max");
    rdReg(RA_MIN, 32'h3, "min");
    press(ESC, 1, 3);
    check("dispMax", 32'h9, 32'(dispValue));
    check("annMax", 32'h1, {31'h0, annMax});
    press(ESC, 1, 3);
    check("dispMin", 32'h3, 32'(dispValue));
    check("annMin", 32'h1, {31'h0, annMin});
    press(ESC, 1, 3);
    check("dispLive", 32'h3, 32'(dispValue));
    check("lamps", 32'h0, {30'h0, annMax, annMin});
    meas(7);
    press(ESC, S + 2, 3);
    rdReg(RA_MAX, 32'h7, "maxReset");
    rdReg(RA_MIN, 32'h7, "minReset");
  endtask : peaks

  task automatic correction;
    wrReg(RA_CORR, 32'h2710);
    rdReg(RA_CORR, 32'h270f, "corrHigh");
    wrReg(RA_CORR, 32'hfffff000);
    rdReg(RA_CORR, 32'hfffff831, "corrLow");
    wrReg(RA_CORR, 32'h5);
    meas(100);
    rdReg(RA_LIVE, 32'h69, "liveCorr");
  endtask : correction

  task automatic adjustLock;
    wrReg(RA_CTRL, 32'h505);
    press(LVL, 1, 3);
    lvlIs(LV_OPER);
    wrReg(RA_CTRL, 32'h501);
    press(LVL, 1, 3);
    lvlIs(LV_ADJ);
    repeat (10 * S - 8) @(posedge clk);
    lvlIs(LV_ADJ);
    repeat (12) @(posedge clk);
    lvlIs(LV_OPER);
  endtask : adjustLock

  task automatic protect;
    press(COMBO, 5 * S - 4, 2);
    lvlIs(LV_OPER);
    press(COMBO, 5 * S + 2, 3);
    lvlIs(LV_PROT);
    press(COMBO, S + 2, 3);
    lvlIs(LV_OPER);
  endtask : protect

  task automatic setupLock;
    wrReg(RA_CTRL, 32'h511);
    press(LVL, 3 * S + 2, 3);
    lvlIs(LV_OPER);
    wrReg(RA_CTRL, 32'h509);
    press(LVL, 3 * S + 2, 3);
    lvlIs(LV_INIT);
    rdReg(RA_STAT, 32'h2, "status");
    press(LVL, S + 2, 3);
    lvlIs(LV_OPER);
  endtask : setupLock

  task automatic editZero;
    wrReg(RA_CTRL, 32'h521);
    press(LVL, 1, 3);
    press(SHIFT, 1, 2);
    press(SHIFT, 1, 2);
    check("svLamp", 32'h1, {31'h0, svLamp});
    check("blinkLocked", 32'h0, {31'h0, blink});
    wrReg(RA_CTRL, 32'h501);
    press(SHIFT, 1, 2);
    check("blink", 32'h1, {31'h0, blink});
    press(UP, 1, 2);
    press(MODE, 1, 2);
    rdReg(RA_CORR, 32'h6, "corrEdit");
    press(LVL, 1, 3);
    wrReg(RA_CTRL, 32'h540);
    press(SHIFT, 1, 2);
    check("zeroLocked", 32'h0, {31'h0, zeroLamp});
    wrReg(RA_CTRL, 32'h500);
    press(SHIFT, 1, 2);
    check("zeroOn", 32'h1, {31'h0, zeroLamp});
    wrReg(RA_TYPE, 32'h9);
    rdReg(RA_TYPE, 32'h5, "typeClamp");
    check("zeroCancel", 32'h0, {31'h0, zeroLamp});
  endtask : editZero

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    peaks;
    correction;
    adjustLock;
    protect;
    setupLock;
    editZero;
    conclude;
  end

  // the sequence needs under 2000 cycles; stop well beyond that
  initial begin
    #200000;
    failCount++;
    conclude;
  end
endmodule : pkp_panel_ctrl_tb
